// file: common/scd_defs.svh
// scd_defs.svh: register offsets, field positions, reset values and timing counts
// for the sample-clock divider and delay block; assumes inclusion before use.
`ifndef SCD_DEFS_SVH
`define SCD_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (10-bit register address)
// ----------------------------------------------------------------
`define SCD_OFS_DIV_RATIO 10'h10b
`define SCD_OFS_HALF_DLY 10'h10c
`define SCD_OFS_FINE_EN 10'h117
`define SCD_OFS_FINE_VAL 10'h118
`define SCD_OFS_SYNC_STATE 10'h10d
`define SCD_OFS_CHAN_SEL 10'h008

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SCD_DIV_SEL_LSB 0
`define SCD_DIV_SEL_MSB 1
`define SCD_FINE_EN_BIT 0
`define SCD_HALF_EN_BIT 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SCD_RST_DIV_RATIO 8'h00
`define SCD_RST_HALF_DLY 8'h00
`define SCD_RST_FINE_EN 8'h00
`define SCD_RST_FINE_VAL 8'h00
`define SCD_RST_SYNC_STATE 8'h00
`define SCD_RST_CHAN_SEL 8'h03

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SCD_FINE_STEP_FS 1700
`define SCD_DP_RESET_CYCLES 4

`endif

// file: common/scd_pkg.sv
// scd_pkg.sv: types shared by the sample-clock divider and delay block.
// assumes scd_defs.svh supplies the numeric constants.
package scd_pkg;

  typedef enum logic [1:0]
  {
    SCD_DIV1 = 2'b00,
    SCD_DIV2 = 2'b01,
    SCD_DIV4 = 2'b10,
    SCD_DIV8 = 2'b11
  } scd_div_e;

  typedef enum logic [1:0]
  {
    SCD_SPI_IDLE = 2'b00,
    SCD_SPI_ADDR = 2'b01,
    SCD_SPI_DATA = 2'b10
  } scd_spi_e;

  typedef logic [7:0] scd_byte_t;

endpackage

// file: rtl/scd_clock_ctrl.sv
// scd_clock_ctrl.sv: sample-clock divider with sysref alignment, per-channel
// half-cycle phase delay and fine-delay codes, programmed over a 3-wire spi port.
// assumes CLK is the input clock; spi pins and sysref arrive asynchronously.
//
// Summary of operation
// - divide input clock by 1,2,4,8
// - divide ratio from divider ratio register
// - valid sysref resets divider to programmed state
// - divider output keeps 50 percent duty at ratios 2,4,8; held high at ratio 1
// - phase delay step is half input cycle
// - half-cycle delay enabled per channel
// - half-cycle write leaves link undisturbed
// - fine delay enabled by bit 0
// - fine delay code is eight bits
// - fine delay spans about 433.5 ps in 1.7 ps steps
// - fine delay value kept per channel
// - fine delay effective immediately on write
// - setting fine enable resets datapath
// - fine value change leaves link undisturbed
`timescale 1ns/100ps
`include "scd_defs.svh"

module scd_clock_ctrl
#(
  parameter int NCHAN = 2,
  parameter int DP_RESET_CYCLES = `SCD_DP_RESET_CYCLES
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // serial port, mode 0, msb first: r/w bit, 15 address bits, 8 data bits
  input wire logic SPI_CS_N,
  input wire logic SPI_SCLK,
  input wire logic SPI_SDI,
  output logic SPI_SDO,
  output logic SPI_SDO_OE,
  // sysref alignment strobe
  input wire logic SYSREF,
  // sample clock, per channel
  output logic [NCHAN-1:0] SAMPLE_CLK,
  output logic [NCHAN-1:0] SAMPLE_EN,
  output logic [NCHAN-1:0] HALF_DLY_EN,
  output logic [NCHAN-1:0] FINE_DLY_EN,
  output logic [8*NCHAN-1:0] FINE_DLY_CODE,
  // datapath reset, not the link
  output logic [NCHAN-1:0] DP_RESET
);
  import scd_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sync1 <= 4'h1;
      sync2 <= 4'h1;
    end
    else
    begin
      sync1 <= {SYSREF, SPI_SDI, SPI_SCLK, SPI_CS_N};
      sync2 <= sync1;
    end
  end

  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;
  logic sysref_s;
  logic sclk_d;
  logic sysref_d;
  assign cs_n_s = sync2[0];
  assign sclk_s = sync2[1];
  assign sdi_s = sync2[2];
  assign sysref_s = sync2[3];

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sclk_d <= 1'b0;
      sysref_d <= 1'b0;
    end
    else
    begin
      sclk_d <= sclk_s;
      sysref_d <= sysref_s;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic sysref_rise;
  assign sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;
  assign sysref_rise = sysref_s & ~sysref_d;

  // ----------------------------------------------------------------
  // serial port framing
  // ----------------------------------------------------------------
  scd_spi_e spi_state;
  logic [4:0] bit_cnt;
  logic [15:0] hdr;
  logic [7:0] wdat;
  logic [7:0] rdat;
  logic wr_stb;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      spi_state <= SCD_SPI_IDLE;
      bit_cnt <= 5'h00;
      hdr <= 16'h0000;
      wdat <= 8'h00;
      wr_stb <= 1'b0;
    end
    else
    begin
      wr_stb <= 1'b0;
      if (cs_n_s)
      begin
        spi_state <= SCD_SPI_IDLE;
        bit_cnt <= 5'h00;
      end
      else if (sclk_rise)
      begin
        case (spi_state)
          SCD_SPI_IDLE, SCD_SPI_ADDR:
          begin
            hdr <= {hdr[14:0], sdi_s};
            bit_cnt <= bit_cnt + 5'h01;
            spi_state <= (bit_cnt == 5'h0f) ? SCD_SPI_DATA : SCD_SPI_ADDR;
            if (bit_cnt == 5'h0f)
            begin
              bit_cnt <= 5'h00;
            end
          end
          SCD_SPI_DATA:
          begin
            wdat <= {wdat[6:0], sdi_s};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'h07)
            begin
              wr_stb <= ~hdr[15];
              spi_state <= SCD_SPI_IDLE;
              bit_cnt <= 5'h00;
            end
          end
          default:
          begin
            spi_state <= SCD_SPI_IDLE;
          end
        endcase
      end
    end
  end

  logic [9:0] reg_addr;
  assign reg_addr = hdr[9:0];

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  scd_byte_t div_ratio;
  scd_byte_t sync_state;
  scd_byte_t chan_sel;
  scd_byte_t half_dly [NCHAN];
  scd_byte_t fine_en [NCHAN];
  scd_byte_t fine_val [NCHAN];
  logic [NCHAN-1:0] fine_rise;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] ofs);
    hit = (a == ofs);
  endfunction

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      div_ratio <= `SCD_RST_DIV_RATIO;
      sync_state <= `SCD_RST_SYNC_STATE;
      chan_sel <= `SCD_RST_CHAN_SEL;
    end
    else if (wr_stb)
    begin
      if (hit(reg_addr, `SCD_OFS_DIV_RATIO))
        div_ratio <= wdat;
      if (hit(reg_addr, `SCD_OFS_SYNC_STATE))
        sync_state <= wdat;
      if (hit(reg_addr, `SCD_OFS_CHAN_SEL))
        chan_sel <= wdat;
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < NCHAN; gc++)
    begin : g_chan
      always_ff @(posedge CLK or negedge RST_N)
      begin
        if (!RST_N)
        begin
          half_dly[gc] <= `SCD_RST_HALF_DLY;
          fine_en[gc] <= `SCD_RST_FINE_EN;
          fine_val[gc] <= `SCD_RST_FINE_VAL;
          fine_rise[gc] <= 1'b0;
        end
        else
        begin
          fine_rise[gc] <= 1'b0;
          if (wr_stb && chan_sel[gc])
          begin
            if (hit(reg_addr, `SCD_OFS_HALF_DLY))
              half_dly[gc] <= wdat;
            if (hit(reg_addr, `SCD_OFS_FINE_EN))
            begin
              fine_en[gc] <= wdat;
              fine_rise[gc] <= wdat[`SCD_FINE_EN_BIT] & ~fine_en[gc][`SCD_FINE_EN_BIT];
            end
            if (hit(reg_addr, `SCD_OFS_FINE_VAL))
              fine_val[gc] <= wdat;
          end
        end
      end

      // codes drive the delay line directly
      // code 0 is earliest, 0xff latest
      assign FINE_DLY_EN[gc] = fine_en[gc][`SCD_FINE_EN_BIT];
      assign FINE_DLY_CODE[8*gc +: 8] = fine_val[gc];
      assign HALF_DLY_EN[gc] = half_dly[gc][`SCD_HALF_EN_BIT];

      // datapath reset pulse on enable; no link reset
      logic [7:0] dp_cnt;
      always_ff @(posedge CLK or negedge RST_N)
      begin
        if (!RST_N)
          dp_cnt <= 8'h00;
        else if (fine_rise[gc])
          dp_cnt <= 8'(DP_RESET_CYCLES);
        else if (dp_cnt != 8'h00)
          dp_cnt <= dp_cnt - 8'h01;
      end
      assign DP_RESET[gc] = (dp_cnt != 8'h00);

      chk_dp_reset_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
        fine_rise[gc] |=> DP_RESET[gc] [*4])
        else $error("datapath reset not held after fine enable");
      chk_fine_immediate: assert property (@(posedge CLK) disable iff (!RST_N)
        (wr_stb && chan_sel[gc] && reg_addr == `SCD_OFS_FINE_VAL) |=> FINE_DLY_CODE[8*gc +: 8] == $past(wdat))
        else $error("fine code did not take the written value");
      chk_val_no_reset: assert property (@(posedge CLK) disable iff (!RST_N)
        (wr_stb && reg_addr == `SCD_OFS_FINE_VAL && !DP_RESET[gc]) |=> !DP_RESET[gc])
        else $error("fine value write reset the datapath");
      chk_half_no_reset: assert property (@(posedge CLK) disable iff (!RST_N)
        (wr_stb && reg_addr == `SCD_OFS_HALF_DLY && !DP_RESET[gc]) |=> !DP_RESET[gc])
        else $error("half-cycle write reset the datapath");
      chk_half_chan: assert property (@(posedge CLK) disable iff (!RST_N)
        (wr_stb && !chan_sel[gc] && reg_addr == `SCD_OFS_HALF_DLY) |=> $stable(HALF_DLY_EN[gc]))
        else $error("unselected channel half delay changed");
    end
  endgenerate

  // ----------------------------------------------------------------
  // readback, driven on falling sclk during data phase
  // ----------------------------------------------------------------
  always_comb
  begin
    rdat = 8'h00;
    case (reg_addr)
      `SCD_OFS_DIV_RATIO: rdat = div_ratio;
      `SCD_OFS_SYNC_STATE: rdat = sync_state;
      `SCD_OFS_CHAN_SEL: rdat = chan_sel;
      `SCD_OFS_HALF_DLY: rdat = chan_sel[0] ? half_dly[0] : half_dly[NCHAN-1];
      `SCD_OFS_FINE_EN: rdat = chan_sel[0] ? fine_en[0] : fine_en[NCHAN-1];
      `SCD_OFS_FINE_VAL: rdat = chan_sel[0] ? fine_val[0] : fine_val[NCHAN-1];
      default: rdat = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      SPI_SDO <= 1'b0;
      SPI_SDO_OE <= 1'b0;
    end
    else
    begin
      SPI_SDO_OE <= ~cs_n_s & hdr[15] & (spi_state == SCD_SPI_DATA);
      if (sclk_fall && spi_state == SCD_SPI_DATA)
        SPI_SDO <= rdat[3'(7 - bit_cnt)];
    end
  end

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // ratio from low two bits
  scd_div_e div_sel;
  logic [2:0] div_cnt;
  logic [2:0] half_len;
  assign div_sel = scd_div_e'(div_ratio[`SCD_DIV_SEL_MSB:`SCD_DIV_SEL_LSB]);

  always_comb
  begin
    case (div_sel)
      SCD_DIV1: half_len = 3'h0;
      SCD_DIV2: half_len = 3'h1;
      SCD_DIV4: half_len = 3'h2;
      SCD_DIV8: half_len = 3'h4;
      default: half_len = 3'h0;
    endcase
  end

  // ratio assumed settled before clock runs; a change is not glitch-guarded
  // valid sysref loads the programmed phase
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      div_cnt <= 3'h0;
    else if (sysref_rise)
      div_cnt <= sync_state[2:0] & ((half_len << 1) - 3'h1);
    else if (div_cnt == ((half_len << 1) - 3'h1) || half_len == 3'h0)
      div_cnt <= 3'h0;
    else
      div_cnt <= div_cnt + 3'h1;
  end

  // high for exactly half the period at ratios 2,4,8; held high at divide by 1
  logic div_clk;
  assign div_clk = (half_len == 3'h0) ? 1'b1 : (div_cnt < half_len);

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      SAMPLE_CLK <= '0;
      SAMPLE_EN <= '0;
    end
    else
    begin
      SAMPLE_CLK <= {NCHAN{div_clk}};
      SAMPLE_EN <= {NCHAN{div_cnt == 3'h0}};
    end
  end

  // a ratio rewrite inside the window moves the terminal count without restarting the count, so the window needs a steady ratio
  chk_div_period: assert property (@(posedge CLK) disable iff (!RST_N)
    (div_sel == SCD_DIV4 && div_cnt == 3'h0 && !sysref_rise) [*1] ##1 (!sysref_rise && div_sel == SCD_DIV4) [*3]
    |=> div_cnt == 3'h0)
    else $error("divide by four period wrong");
  chk_sysref_align: assert property (@(posedge CLK) disable iff (!RST_N)
    sysref_rise |=> div_cnt == ($past(sync_state[2:0]) & (($past(half_len) << 1) - 3'h1)))
    else $error("divider not realigned by sysref");
  chk_duty_half: assert property (@(posedge CLK) disable iff (!RST_N)
    (div_sel == SCD_DIV2 && !sysref_rise && $stable(div_ratio) && div_cnt == 3'h0)
    |-> div_clk ##1 (!div_clk || sysref_rise || !$stable(div_ratio)))
    else $error("divide by two duty not 50 percent");

endmodule

// file: verification/scd_clock_ctrl_test.sv
// scd_clock_ctrl_test.sv: self-checking bench for the sample-clock divider block.
// assumes the host model for spi access; sysref and reset come from here.
`timescale 1ns/100ps
`include "scd_defs.svh"
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
    end \
  end

module scd_clock_ctrl_test;
  import scd_pkg::*;
  localparam int DPN = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sysref = 1'b0;
  logic cs_n, sclk, sdi, sdo, sdo_oe;
  logic [1:0] sample_clk, sample_en, half_en, fine_en, dp_reset;
  logic [15:0] fine_code;
  int checks = 0;
  int fails = 0;
  int dp_a = 0;
  int dp_b = 0;
  int oe_cyc = 0;
  int n, d0, d1, d4;
  scd_byte_t r8;

  always #25 clk = ~clk;

  scd_host_model host (.CLK(clk), .SPI_CS_N(cs_n), .SPI_SCLK(sclk), .SPI_SDI(sdi), .SPI_SDO(sdo));

  scd_clock_ctrl #(.NCHAN(2), .DP_RESET_CYCLES(DPN)) DUT
  (
    .CLK(clk), .RST_N(rst_n), .SPI_CS_N(cs_n), .SPI_SCLK(sclk), .SPI_SDI(sdi),
    .SPI_SDO(sdo), .SPI_SDO_OE(sdo_oe), .SYSREF(sysref), .SAMPLE_CLK(sample_clk),
    .SAMPLE_EN(sample_en), .HALF_DLY_EN(half_en), .FINE_DLY_EN(fine_en),
    .FINE_DLY_CODE(fine_code), .DP_RESET(dp_reset)
  );

  // cycles of datapath reset seen per channel
  always @(posedge clk)
  begin
    if (dp_reset[0] === 1'b1)
      dp_a++;
    if (dp_reset[1] === 1'b1)
      dp_b++;
    if (sdo_oe === 1'b1)
      oe_cyc++;
  end

  task automatic wr(input logic [9:0] a, input scd_byte_t d);
    scd_byte_t r;
    host.xfer(1'b0, {5'h00, a}, d, r);
  endtask

  task automatic rd(input logic [9:0] a, output scd_byte_t d);
    host.xfer(1'b1, {5'h00, a}, 8'h00, d);
  endtask

  // high cycles of channel A sample enable (sel 0) or sample clock (sel 1) over 16 cycles
  task automatic count_hi(input int sel, output int cnt);
    cnt = 0;
    repeat (16)
    begin
      @(posedge clk);
      #1;
      if ((sel == 0) ? (sample_en[0] === 1'b1) : (sample_clk[0] === 1'b1))
        cnt++;
    end
  endtask

  // cycles from a sysref rise to the next channel A sample enable
  task automatic sysref_delay(input int pre, output int d);
    repeat (pre) @(negedge clk);
    sysref = 1'b1;
    repeat (3) @(negedge clk);
    sysref = 1'b0;
    // the enable seen at this edge still belongs to the old phase
    @(negedge clk);
    d = 4;
    while (sample_en[0] !== 1'b1 && d < 40)
    begin
      @(negedge clk);
      d++;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog: about 25 frames of some 230 cycles, with ample margin
  // ----------------------------------------------------------------
  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    stop_test();
  end

  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    `CHK(fine_en, 2'b00)
    `CHK(dp_reset, 2'b00)
    rd(`SCD_OFS_DIV_RATIO, r8);
    `CHK(r8, `SCD_RST_DIV_RATIO)
    rd(`SCD_OFS_FINE_VAL, r8);
    `CHK(r8, `SCD_RST_FINE_VAL)
    oe_cyc = 0;
    wr(10'h055, 8'h5a);
    `CHK(oe_cyc, 0)
    rd(10'h055, r8);
    `CHK(r8, 8'h00)
    `CHK(oe_cyc > 0, 1'b1)
    `CHK(sdo_oe, 1'b0)
    $display("test reset_and_map done");

    // every ratio code, read back and counted
    for (int r = 0; r < 4; r++)
    begin
      wr(`SCD_OFS_DIV_RATIO, r[7:0]);
      rd(`SCD_OFS_DIV_RATIO, r8);
      `CHK(r8, r[7:0])
      count_hi(0, n);
      `CHK(n, 16 >> r)
      if (r > 0)
      begin
        count_hi(1, n);
        `CHK(n, 8)
      end
    end
    $display("test divide_ratios done");

    // alignment repeats at any phase; loaded state shifts it
    sysref_delay(5, d0);
    sysref_delay(11, d1);
    `CHK(d1, d0)
    wr(`SCD_OFS_SYNC_STATE, 8'h04);
    sysref_delay(7, d4);
    `CHK((d4 - d0 + 8) % 8, 4)
    $display("test sysref_align done");

    dp_a = 0;
    dp_b = 0;
    wr(`SCD_OFS_CHAN_SEL, 8'h02);
    wr(`SCD_OFS_HALF_DLY, 8'h01);
    `CHK(half_en, 2'b10)
    `CHK(dp_a + dp_b, 0)
    wr(`SCD_OFS_CHAN_SEL, 8'h01);
    wr(`SCD_OFS_HALF_DLY, 8'h01);
    `CHK(half_en, 2'b11)
    $display("test half_cycle done");

    // per-channel codes at the range ends
    wr(`SCD_OFS_FINE_VAL, 8'hff);
    wr(`SCD_OFS_CHAN_SEL, 8'h02);
    wr(`SCD_OFS_FINE_VAL, 8'h00);
    `CHK(fine_code, 16'h00ff)
    wr(`SCD_OFS_CHAN_SEL, 8'h01);
    dp_a = 0;
    wr(`SCD_OFS_FINE_EN, 8'h01);
    `CHK(fine_en, 2'b01)
    `CHK(dp_a, DPN)
    `CHK(dp_b, 0)
    dp_a = 0;
    wr(`SCD_OFS_FINE_VAL, 8'ha5);
    `CHK(fine_code[7:0], 8'ha5)
    `CHK(dp_a, 0)
    wr(`SCD_OFS_CHAN_SEL, 8'h03);
    rd(`SCD_OFS_FINE_VAL, r8);
    `CHK(r8, 8'ha5)
    $display("test fine_delay done");
    stop_test();
  end
endmodule

// file: verification/scd_host_model.sv
// scd_host_model.sv: host-side spi master that programs the block's registers.
// assumes a free-running CLK; pins change only on its falling edge.
`timescale 1ns/100ps

module scd_host_model
(
  // clock
  input wire logic CLK,
  // serial port
  output logic SPI_CS_N,
  output logic SPI_SCLK,
  output logic SPI_SDI,
  input wire logic SPI_SDO
);
  initial
  begin
    SPI_CS_N = 1'b1;
    SPI_SCLK = 1'b0;
    SPI_SDI = 1'b1;
  end

  // ----------------------------------------------------------------
  // one frame: r/w bit, 15 address bits, 8 data bits, msb first
  // ----------------------------------------------------------------
  // host sets the ratio before relying on the clock
  task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [23:0] frame;
    frame = {rd, addr, wdata};
    rdata = 8'h00;
    @(negedge CLK);
    SPI_CS_N = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      SPI_SDI = frame[i];
      // low phase longer than high: sdo lags the fall by the sync stages
      repeat (5) @(negedge CLK);
      SPI_SCLK = 1'b1;
      if (i < 8)
        rdata[i] = SPI_SDO;
      repeat (4) @(negedge CLK);
      SPI_SCLK = 1'b0;
    end
    repeat (2) @(negedge CLK);
    SPI_CS_N = 1'b1;
    // released line shows a changed level, never the last bit
    SPI_SDI = ~SPI_SDI;
    repeat (8) @(negedge CLK);
  endtask
endmodule
